// File: bench/clb_mem_model.sv
/*
  Memory and I/O model on the far side of the local bus.
  Assumes the pin bundle of the bus control block and one clock.
*/
`timescale 1ns/1ps
module clb_mem_model
  import clb_pkg::*;
(
  // Clock, pins and wait setting
  input wire logic MCLK,
  input wire clb_pins_t PINS,
  input wire logic [3:0] WAITS,
  // Answers
  output logic [DATA_W-1:0] BUS_I,
  output logic READY
);
  logic [DATA_W-1:0] mem [16];
  logic [3:0] idx_q;
  logic [3:0] cnt_q = 4'h0;
  logic [DATA_W-1:0] last_q = 16'h0000;
  logic rd;
  logic ak;
  logic act;
  assign rd = !PINS.read_strobe_n;
  assign ak = !PINS.irq_ack_strobe_n;
  assign act = rd || ak || !PINS.write_strobe_n;
  initial for (int i = 0; i < 16; i++) mem[i] = {4{i[3:0]}};
  always @(posedge MCLK) begin
    if (PINS.addr_latch_strobe)
      idx_q <= {PINS.mem_io_select, PINS.mux_addr_data_bus[2:0]};
    if (!PINS.write_strobe_n)
      mem[idx_q] <= PINS.mux_addr_data_bus;
    cnt_q <= act ? cnt_q + 4'h1 : 4'h0;
    last_q <= BUS_I;
  end
  // Ready is held low for the first WAITS+1 strobe cycles, giving WAITS wait states.
  assign READY = !act || cnt_q > WAITS;
  // A released bus toggles so that a stale value cannot pass.
  assign BUS_I = PINS.mux_addr_data_bus_oe ? PINS.mux_addr_data_bus :
                 ak ? 16'h0042 : rd ? mem[idx_q] : ~last_q;
endmodule // clb_mem_model

// File: bench/cpu_local_bus_control_bench.sv
/*
  Self-checking bench for the local-bus control sequencer.
  Assumes the memory model above on the far side of the bus.
*/
`timescale 1ns/1ps
module cpu_local_bus_control_bench;
  import clb_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic lock_req = 1'b0;
  logic hold_req = 1'b0;
  logic grant_i = 1'b1;
  logic mode = 1'b1;
  logic [1:0] qs_in = 2'h0;
  logic [3:0] waits = 4'h0;
  clb_req_t req = '0;
  logic req_ready;
  logic done;
  logic ready;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] bus_i;
  clb_pins_t pins;
  logic grant_w;
  logic [2:0] st_tab [5] = '{ST_MEM_RD, ST_MEM_WR, ST_IO_RD, ST_IO_WR,
                             ST_IRQ_ACK};
  int mismatches = 0;
  int num_checks = 0;
  int n;
  // The grant line idles high; the block pulls it low when it grants.
  assign grant_w = grant_i &
    !(pins.master_req_grant_oe & !pins.master_req_grant_o);
  clb_bus_ctrl u_clb_bus_ctrl (.MCLK(mclk), .SRST(srst), .CE(1'b1),
    .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
    .DONE(done), .RDATA(rdata), .LOCK_REQ(lock_req),
    .QUEUE_STATE_IN(qs_in), .CONFIG_MODE_SELECT(mode),
    .MUX_ADDR_DATA_BUS_I(bus_i), .BUS_READY(ready),
    .BUS_HOLD_REQ(hold_req), .MASTER_REQ_GRANT_I(grant_w),
    .BUS_PINS(pins));
  clb_mem_model u_clb_mem_model (.MCLK(mclk), .PINS(pins),
    .WAITS(waits), .BUS_I(bus_i), .READY(ready));
  initial forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
  task chk(logic [63:0] got, logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task rst(logic m);
    @(posedge mclk) srst <= 1'b1;
    mode <= m;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk({pins, req_ready, done}, {PINS_RST, 2'b00});
    @(posedge mclk) srst <= 1'b0;
  endtask
  // Checks T1 and T2 pins, then the length of the whole cycle.
  task op(clb_kind_t k, logic [19:0] a, logic [15:0] d, logic ub,
          logic [15:0] er, int lat);
    logic mio, wr, ak, flt;
    mio = k inside {K_MEM_RD, K_MEM_WR};
    wr = k inside {K_MEM_WR, K_IO_WR};
    ak = k == K_IRQ_ACK;
    @(negedge mclk);
    while (req_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk) req_valid <= 1'b1;
    req <= '{k, a, d, ub};
    @(posedge mclk) req_valid <= 1'b0;
    @(negedge mclk);
    flt = pins.mux_addr_data_bus_oe;
    if (mode) begin
      chk({pins.addr_latch_strobe, pins.mem_io_select, pins.xcvr_direction},
        {1'b1, mio, wr});
      chk({pins.upper_addr_bits, pins.upper_byte_enable_n},
        {mio ? a[19:16] : 4'h0, !ub});
    end else begin
      chk({pins.addr_latch_strobe, pins.bus_status},
        {1'b1, st_tab[k]});
    end
    if (!ak) chk(pins.mux_addr_data_bus, a[15:0]);
    @(negedge mclk);
    if (mode) chk({pins.read_strobe_n, pins.write_strobe_n,
      pins.irq_ack_strobe_n, pins.xcvr_output_enable_n},
      {wr || ak, !wr, !ak, 1'b0});
    else chk({pins.read_strobe_n, pins.write_strobe_n,
      pins.irq_ack_strobe_n, pins.xcvr_output_enable_n},
      {wr || ak, 3'b111});
    if (wr) chk(pins.mux_addr_data_bus, d);
    n = 2;
    while (done !== 1'b1 && n < 40) begin
      flt |= pins.mux_addr_data_bus_oe;
      @(negedge mclk);
      n++;
    end
    chk(n, lat);
    if (ak) chk(flt, 1'b0);
    if (!wr) chk(rdata, er);
    @(negedge mclk);
    chk(done, 1'b0);
  endtask
  initial begin
    rst(1'b1);
    op(K_MEM_WR, 20'h30005, 16'hbeef, 1'b1, 16'h0, 5);
    op(K_IO_WR, 20'h00005, 16'h1234, 1'b0, 16'h0, 5);
    op(K_MEM_RD, 20'h30005, 16'h0, 1'b1, 16'hbeef, 5);
    waits = 4'h1;
    op(K_IO_RD, 20'h00005, 16'h0, 1'b0, 16'h1234, 6);
    waits = 4'h2;
    op(K_MEM_RD, 20'hf0002, 16'h0, 1'b0, 16'haaaa, 7);
    waits = 4'h0;
    op(K_IRQ_ACK, 20'h0, 16'h0, 1'b0, 16'h0042, 9);
    @(posedge mclk) hold_req <= 1'b1;
    repeat (2) @(negedge mclk);
    chk({pins.bus_release_ack, pins.ctrl_oe, pins.mux_addr_data_bus_oe,
      req_ready}, 4'b1000);
    @(posedge mclk) hold_req <= 1'b0;
    @(negedge mclk);
    chk(pins.bus_release_ack, 1'b1);
    @(negedge mclk);
    chk({pins.bus_release_ack, pins.ctrl_oe}, 2'b01);
    rst(1'b0);
    op(K_MEM_WR, 20'h10001, 16'h5555, 1'b0, 16'h0, 5);
    op(K_IO_RD, 20'h00005, 16'h0, 1'b0, 16'h1234, 5);
    @(posedge mclk) lock_req <= 1'b1;
    qs_in <= 2'h2;
    repeat (2) @(negedge mclk);
    chk({pins.bus_lock_n, pins.queue_state}, 3'b010);
    @(posedge mclk) grant_i <= 1'b0;
    lock_req <= 1'b0;
    @(posedge mclk) grant_i <= 1'b1;
    n = 0;
    repeat (4) begin
      @(negedge mclk);
      if (pins.master_req_grant_oe === 1'b1) n++;
    end
    chk(n, 1);
    chk({req_ready, pins.ctrl_oe}, 2'b00);
    @(posedge mclk) grant_i <= 1'b0;
    @(posedge mclk) grant_i <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(req_ready, 1'b1);
    // A request met during a cycle is granted only after its T4.
    fork
      op(K_IO_RD, 20'h00005, 16'h0, 1'b0, 16'h1234, 5);
      begin
        repeat (3) @(posedge mclk);
        grant_i <= 1'b0;
        @(posedge mclk) grant_i <= 1'b1;
      end
    join
    chk({req_ready, pins.ctrl_oe}, 2'b00);
    @(posedge mclk) grant_i <= 1'b0;
    @(posedge mclk) grant_i <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(req_ready, 1'b1);
    end_sim();
  end
endmodule // cpu_local_bus_control_bench

// File: core/clb_bus_ctrl.sv
/*
  Local-bus control sequencer: runs T-state bus cycles and drives the
  strobes, address, data, status and bus-release pins.
  Assumes synchronous inputs, reset held at least four clocks, and a
  testbench that resolves the three-signal pins into wires.
*/
// How it works
// - Interrupt-acknowledge strobe low in T2, T3 and wait states.
// - Address latch strobe pulses in T1 of every bus cycle.
// - Transceiver enable low from T2 to T4 of memory, I/O and acknowledge cycles.
// - Transceiver direction is transmit for writes, receive for reads.
// - Memory/IO select marks memory cycles for the whole access.
// - Write strobe asserted in write cycles to memory or I/O.
// - Read strobe asserted in read cycles to memory or I/O.
// - Hold request high gives hold acknowledge and floats local bus.
// - Bus driven again one cycle after hold request falls.
// - Mode input, caught at reset, picks minimum or maximum pins.
// - Upper-byte enable qualifies transfers on the upper data half.
// - Top four address bits for memory, low for I/O.
// - Maximum mode presents encoded status for an external controller.
// - Maximum mode outputs two-bit queue state.
// - Maximum mode asserts lock while a locked instruction runs.
// - Request/grant pulse releases bus at end of current cycle.
// - Address on shared lines in T1, data later, floated otherwise.
// - Two acknowledge cycles run back to back with lines floated.
// - Ready sampled in T3 and waits; low inserts wait states.
`timescale 1ns/1ps
module clb_bus_ctrl
  import clb_pkg::*;
(
  // Clock, reset, freeze
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  // Cycle requests from the execution side
  input wire logic REQ_VALID,
  input wire clb_req_t REQ,
  output logic REQ_READY,
  output logic DONE,
  output logic [DATA_W-1:0] RDATA,
  input wire logic LOCK_REQ,
  input wire logic [1:0] QUEUE_STATE_IN,
  // Configuration, high selects minimum mode
  input wire logic CONFIG_MODE_SELECT,
  // Bus pins
  input wire logic [DATA_W-1:0] MUX_ADDR_DATA_BUS_I,
  input wire logic BUS_READY,
  input wire logic BUS_HOLD_REQ,
  input wire logic MASTER_REQ_GRANT_I,
  output clb_pins_t BUS_PINS
);
  clb_state_t state_q, state_d;
  clb_req_t req_q, req_d;
  clb_pins_t pins_q, pins_d;
  logic ack2_q, ack2_d;
  logic rq_pend_q, rq_pend_d;
  logic rq_prev_q;
  logic min_q;
  logic done_q, done_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic rq_pulse, hold_want, active, strobe, released;
  logic is_rd, is_wr, is_ack, is_mem;

  // The grant line idles high; a one-clock low from the other master is
  // a request or, once lent, the return of the bus.
  assign rq_pulse = !min_q && rq_prev_q && !MASTER_REQ_GRANT_I;
  assign hold_want = min_q && BUS_HOLD_REQ;
  // Hold and grant win over a new request so a waiting master is served.
  // Nothing is taken while reset is held, as the cycle would be lost.
  assign REQ_READY = CE && !SRST && state_q == S_IDLE && !hold_want &&
    !rq_pend_q;

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    ack2_d = ack2_q;
    rq_pend_d = rq_pend_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      S_IDLE: begin
        if (hold_want) begin
          state_d = S_HELD;
        end else if (rq_pend_q) begin
          state_d = S_GRANT;
        end else if (REQ_VALID) begin
          req_d = REQ;
          ack2_d = 1'b0;
          state_d = S_T1;
        end
      end
      S_T1: state_d = S_T2;
      S_T2: state_d = S_T3;
      S_T3, S_TW: begin
        if (BUS_READY) begin
          state_d = S_T4;
          if (req_q.kind != K_MEM_WR && req_q.kind != K_IO_WR) begin
            rdata_d = MUX_ADDR_DATA_BUS_I;
          end
        end else begin
          state_d = S_TW;
        end
      end
      S_T4: begin
        if (req_q.kind == K_IRQ_ACK && !ack2_q) begin
          ack2_d = 1'b1;
          state_d = S_T1;
        end else begin
          done_d = 1'b1;
          state_d = rq_pend_q ? S_GRANT : S_IDLE;
        end
      end
      S_HELD: if (!BUS_HOLD_REQ) state_d = S_IDLE;
      S_GRANT: begin
        rq_pend_d = 1'b0;
        state_d = S_LENT;
      end
      S_LENT: if (rq_pulse) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
    if (rq_pulse && state_q != S_GRANT && state_q != S_LENT) begin
      rq_pend_d = 1'b1;
    end
  end

  // Pins follow the next state so they change on the same edge as it.
  always_comb begin
    pins_d = PINS_RST;
    active = state_d inside {S_T1, S_T2, S_T3, S_TW, S_T4};
    strobe = state_d inside {S_T2, S_T3, S_TW};
    released = state_d inside {S_HELD, S_GRANT, S_LENT};
    is_rd = req_d.kind == K_MEM_RD || req_d.kind == K_IO_RD;
    is_wr = req_d.kind == K_MEM_WR || req_d.kind == K_IO_WR;
    is_ack = req_d.kind == K_IRQ_ACK;
    is_mem = req_d.kind == K_MEM_RD || req_d.kind == K_MEM_WR;
    pins_d.ctrl_oe = !released;
    pins_d.addr_latch_strobe = state_d == S_T1;
    pins_d.read_strobe_n = !(strobe && is_rd);
    pins_d.upper_byte_enable_n = !(active && req_d.upper_byte);
    if (active && is_mem) begin
      pins_d.upper_addr_bits = req_d.addr[HI_LSB +: HI_W];
    end
    if (state_d == S_T1 && !is_ack) begin
      pins_d.mux_addr_data_bus = req_d.addr[DATA_W-1:0];
      pins_d.mux_addr_data_bus_oe = 1'b1;
    end else if (active && state_d != S_T1 && is_wr) begin
      pins_d.mux_addr_data_bus = req_d.wdata;
      pins_d.mux_addr_data_bus_oe = 1'b1;
    end
    if (min_q) begin
      pins_d.write_strobe_n = !(strobe && is_wr);
      pins_d.irq_ack_strobe_n = !(strobe && is_ack);
      pins_d.mem_io_select = active && is_mem;
      pins_d.xcvr_output_enable_n = !(active && state_d != S_T1);
      pins_d.xcvr_direction = !(active && !is_wr);
      pins_d.bus_release_ack = state_d == S_HELD;
    end else begin
      if (active && state_d != S_T4) begin
        case (req_d.kind)
          K_MEM_RD: pins_d.bus_status = ST_MEM_RD;
          K_MEM_WR: pins_d.bus_status = ST_MEM_WR;
          K_IO_RD: pins_d.bus_status = ST_IO_RD;
          K_IO_WR: pins_d.bus_status = ST_IO_WR;
          default: pins_d.bus_status = ST_IRQ_ACK;
        endcase
      end
      pins_d.queue_state = QUEUE_STATE_IN;
      pins_d.bus_lock_n = !LOCK_REQ;
      pins_d.master_req_grant_oe = state_d == S_GRANT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      // Mode is caught every reset cycle, so the value at release stays.
      min_q <= CONFIG_MODE_SELECT;
      state_q <= S_IDLE;
      req_q <= '0;
      ack2_q <= 1'b0;
      rq_pend_q <= 1'b0;
      rq_prev_q <= 1'b1;
      done_q <= 1'b0;
      rdata_q <= '0;
      pins_q <= PINS_RST;
    end else if (CE) begin
      state_q <= state_d;
      req_q <= req_d;
      ack2_q <= ack2_d;
      rq_pend_q <= rq_pend_d;
      rq_prev_q <= MASTER_REQ_GRANT_I;
      done_q <= done_d;
      rdata_q <= rdata_d;
      pins_q <= pins_d;
    end
  end

  assign BUS_PINS = pins_q;
  assign DONE = done_q;
  assign RDATA = rdata_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST || !CE);

  sequence s_t_order;
    state_q == S_T2 ##1 state_q == S_T3;
  endsequence
  sequence s_released;
    pins_q.bus_release_ack && !pins_q.ctrl_oe;
  endsequence

  a_ale_one_pulse: assert property (pins_q.addr_latch_strobe |=>
    !pins_q.addr_latch_strobe && !pins_q.read_strobe_n == (req_q.kind
    inside {K_MEM_RD, K_IO_RD}))
    else $error("address strobe not a single T1 pulse");
  a_ack_strobe_low: assert property (min_q &&
    req_q.kind == K_IRQ_ACK && state_q inside {S_T2, S_T3, S_TW} |->
    !pins_q.irq_ack_strobe_n)
    else $error("acknowledge strobe high in T2/T3/TW");
  a_xcvr_enable: assert property (min_q && state_q inside
    {S_T2, S_T3, S_TW, S_T4} |-> !pins_q.xcvr_output_enable_n)
    else $error("transceiver enable inactive during access");
  a_xcvr_dir: assert property (min_q && state_q == S_T2 |->
    pins_q.xcvr_direction == (req_q.kind inside {K_MEM_WR, K_IO_WR}))
    else $error("transceiver direction wrong");
  a_mem_io_held: assert property (min_q && state_q == S_T1 &&
    req_q.kind inside {K_MEM_RD, K_MEM_WR} |-> pins_q.mem_io_select [*3])
    else $error("memory select dropped within access");
  a_write_strobe: assert property (min_q && state_q == S_T3 &&
    req_q.kind inside {K_MEM_WR, K_IO_WR} |-> !pins_q.write_strobe_n)
    else $error("write strobe missing");
  a_read_strobe: assert property (state_q == S_T3 && req_q.kind
    inside {K_MEM_RD, K_IO_RD} |-> !pins_q.read_strobe_n)
    else $error("read strobe missing");
  a_hold_ack: assert property (state_q == S_IDLE && hold_want
    |=> s_released)
    else $error("hold not acknowledged with bus floated");
  a_hold_resume: assert property (state_q == S_HELD &&
    !BUS_HOLD_REQ |=> pins_q.ctrl_oe && !pins_q.bus_release_ack)
    else $error("bus not resumed one cycle after hold");
  a_upper_addr_io: assert property (state_q != S_IDLE && req_q.kind
    inside {K_IO_RD, K_IO_WR} |-> pins_q.upper_addr_bits == 4'h0)
    else $error("upper address not low for I/O");
  a_status_passive: assert property (!min_q && state_q == S_T4
    |-> pins_q.bus_status == ST_PASSIVE)
    else $error("status not passive in T4");
  a_grant_at_end: assert property (state_q == S_T4 && rq_pend_q &&
    (req_q.kind != K_IRQ_ACK || ack2_q) |=> pins_q.master_req_grant_oe)
    else $error("grant not given at end of cycle");
  a_ack_float: assert property (req_q.kind == K_IRQ_ACK && state_q
    inside {S_T1, S_T2, S_T3, S_TW, S_T4} |-> !pins_q.mux_addr_data_bus_oe)
    else $error("shared lines driven during acknowledge");
  a_ready_wait: assert property (state_q inside {S_T3, S_TW} &&
    !BUS_READY |=> state_q == S_TW)
    else $error("wait state not inserted");
  a_t_order: assert property (state_q == S_T1 |=> s_t_order)
    else $error("T-states out of order");

  // The second acknowledge cycle starts straight after the first T4.
  sequence s_ack_second;
    state_q == S_T1 && ack2_q;
  endsequence

  a_ale_only_t1: assert property (pins_q.addr_latch_strobe ==
    (state_q == S_T1))
    else $error("address strobe outside T1");
  a_ack_no_rw: assert property (req_q.kind == K_IRQ_ACK && state_q
    inside {S_T2, S_T3, S_TW} |-> pins_q.read_strobe_n &&
    pins_q.write_strobe_n)
    else $error("read or write strobe during acknowledge");
  a_ack_twice: assert property (state_q == S_T4 &&
    req_q.kind == K_IRQ_ACK && !ack2_q |=> s_ack_second)
    else $error("second acknowledge cycle missing");
  a_upper_byte: assert property (state_q inside
    {S_T1, S_T2, S_T3, S_TW, S_T4} |->
    pins_q.upper_byte_enable_n == !req_q.upper_byte)
    else $error("upper-byte enable wrong during access");
  a_upper_addr_mem: assert property (state_q inside
    {S_T1, S_T2, S_T3, S_TW, S_T4} && req_q.kind inside
    {K_MEM_RD, K_MEM_WR} |-> pins_q.upper_addr_bits ==
    req_q.addr[HI_LSB +: HI_W])
    else $error("upper address bits wrong for memory");
  a_addr_in_t1: assert property (state_q == S_T1 &&
    req_q.kind != K_IRQ_ACK |-> pins_q.mux_addr_data_bus_oe &&
    pins_q.mux_addr_data_bus == req_q.addr[DATA_W-1:0])
    else $error("address not driven in T1");
  a_write_data: assert property (state_q inside
    {S_T2, S_T3, S_TW, S_T4} && req_q.kind inside {K_MEM_WR, K_IO_WR}
    |-> pins_q.mux_addr_data_bus_oe &&
    pins_q.mux_addr_data_bus == req_q.wdata)
    else $error("write data not driven after T1");
  a_held_float: assert property (state_q inside
    {S_HELD, S_GRANT, S_LENT} |-> !pins_q.ctrl_oe &&
    !pins_q.mux_addr_data_bus_oe)
    else $error("local bus driven while released");
  // Pins of the other mode must stay at their idle levels.
  a_max_quiet: assert property (!min_q |-> pins_q.write_strobe_n &&
    pins_q.irq_ack_strobe_n && pins_q.xcvr_output_enable_n &&
    pins_q.xcvr_direction && !pins_q.mem_io_select &&
    !pins_q.bus_release_ack)
    else $error("minimum-mode pin active in maximum mode");
  a_min_quiet: assert property (min_q |->
    pins_q.bus_status == ST_PASSIVE && pins_q.bus_lock_n &&
    pins_q.queue_state == 2'h0 && !pins_q.master_req_grant_oe)
    else $error("maximum-mode pin active in minimum mode");
  a_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
endmodule // clb_bus_ctrl

// File: core/clb_pkg.sv
/*
  Shared constants and types for the local-bus control block.
  Assumes a single 10 MHz clock and a user side that issues one bus
  cycle request at a time.
*/
package clb_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int HI_W = 4;
  localparam int HI_LSB = 16;
  localparam int CLK_PERIOD_NS = 100;
  // Status encodings presented in maximum configuration.
  localparam logic [2:0] ST_IRQ_ACK = 3'h0;
  localparam logic [2:0] ST_IO_RD = 3'h1;
  localparam logic [2:0] ST_IO_WR = 3'h2;
  localparam logic [2:0] ST_MEM_RD = 3'h5;
  localparam logic [2:0] ST_MEM_WR = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;

  typedef enum logic [2:0] {
    K_MEM_RD, K_MEM_WR, K_IO_RD, K_IO_WR, K_IRQ_ACK
  } clb_kind_t;

  typedef enum logic [3:0] {
    S_IDLE, S_T1, S_T2, S_T3, S_TW, S_T4, S_HELD, S_GRANT, S_LENT
  } clb_state_t;

  typedef struct packed {
    clb_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic upper_byte;
  } clb_req_t;

  typedef struct packed {
    logic ctrl_oe;
    logic addr_latch_strobe;
    logic read_strobe_n;
    logic write_strobe_n;
    logic mem_io_select;
    logic xcvr_output_enable_n;
    logic xcvr_direction;
    logic irq_ack_strobe_n;
    logic upper_byte_enable_n;
    logic [HI_W-1:0] upper_addr_bits;
    logic [DATA_W-1:0] mux_addr_data_bus;
    logic mux_addr_data_bus_oe;
    logic bus_release_ack;
    logic [2:0] bus_status;
    logic [1:0] queue_state;
    logic bus_lock_n;
    logic master_req_grant_o;
    logic master_req_grant_oe;
  } clb_pins_t;

  localparam clb_pins_t PINS_RST = '{
    ctrl_oe: 1'b0, addr_latch_strobe: 1'b0, read_strobe_n: 1'b1,
    write_strobe_n: 1'b1, mem_io_select: 1'b0,
    xcvr_output_enable_n: 1'b1, xcvr_direction: 1'b1,
    irq_ack_strobe_n: 1'b1, upper_byte_enable_n: 1'b1,
    upper_addr_bits: 4'h0, mux_addr_data_bus: 16'h0000,
    mux_addr_data_bus_oe: 1'b0, bus_release_ack: 1'b0,
    bus_status: ST_PASSIVE, queue_state: 2'h0, bus_lock_n: 1'b1,
    master_req_grant_o: 1'b0, master_req_grant_oe: 1'b0};
endpackage
